//--- core/sas_pkg.sv
// constants, register map and types for the converter sequencer
package sas_pkg;
  // register byte offsets and decode fields
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] TRIG_OFF = 8'h04;
  localparam logic [2:0] RES_SEL = 3'h1; // results at 8'h20..8'h3c
  localparam int NCH = 8;
  localparam int CH_W = 3;
  localparam int RES_W = 10;
  localparam int CNT_W = 7;
  localparam int GO_BIT = 5;
  localparam int DONE_BIT = 7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] TRIG_ONES = 6'h3f;
  localparam logic [RES_W-1:0] RES_RST = 10'h000;
  localparam logic [RES_W-1:0] SAR_TOP = 10'h200;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  // timing in converter states; one state lasts STATE_NS
  localparam int STATE_NS = 8;
  localparam int CLK_NS = 8;
  localparam int TD_SLOW = 6;
  localparam int TD_FAST = 4;
  localparam int SPL_SLOW = 31;
  localparam int SPL_FAST = 15;
  localparam int TOT_SLOW = 131;
  localparam int TOT_FAST = 69;
  localparam int REP_SLOW = 128;
  localparam int REP_FAST = 66;
  localparam int CNV_SLOW = TOT_SLOW - TD_SLOW - SPL_SLOW;
  localparam int CNV_FAST = TOT_FAST - TD_FAST - SPL_FAST;
  localparam int GAP_SLOW = REP_SLOW - SPL_SLOW - CNV_SLOW;
  localparam int GAP_FAST = REP_FAST - SPL_FAST - CNV_FAST;
  // states to clock cycles, least times rounded up
  function automatic int cyc(input int st);
    return (st * STATE_NS + CLK_NS - 1) / CLK_NS;
  endfunction : cyc
  // control and status register layout
  typedef struct packed {
    logic done;
    logic irq_en;
    logic go;
    logic scan;
    logic speed;
    logic [CH_W-1:0] ch;
  } sas_ctrl_t;
  typedef struct packed {
    logic en;
    logic rsv0;
  } sas_trig_t;
  // sequencer states, gray along idle-delay-sample-convert-gap
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DELAY = 3'h1,
    ST_SAMP = 3'h3,
    ST_CONV = 3'h2,
    ST_GAP = 3'h6
  } sas_state_t;
endpackage : sas_pkg

//--- core/sas_sar_adc_seq.sv
// sar converter sequencer with ahb-lite register slave
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - 10-bit successive approximation, single or scan
// - one write may set go and settings
// - single mode converts selected channel once
// - single result lands in channel's register
// - single completion sets done, irq if enabled
// - go reads 1, self-clears, back to wait
// - scan up to four, from input 0/4
// - scan stores each channel's result in turn
// - pass end sets done, restarts group
// - scan go never self-clears, repeats passes
// - start delay before sampling, speed dependent
// - first conversion 131 or 69 states
// - later scan conversions 128 or 66 states
// - enabled trigger falling edge sets go
// - triggered start behaves like software start
// - mode 0 single, 1 scan; reset 0
// - standby or reset also clears go
// - speed bit selects 131 or 69 states
// - channel field selects input or group span
module sas_sar_adc_seq
  import sas_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ext_trigger_pin_n,
  input wire logic standby,
  input wire logic cmp_hi,
  output logic [CH_W-1:0] an_sel,
  output logic sample_en,
  output logic [RES_W-1:0] dac_code,
  output logic conv_done_irq
);

  ////////////////////////////////////////////////////////////////////////
  // declarations
  sas_ctrl_t conv_ctrl_status_reg;
  sas_trig_t trigger_ctrl_reg;
  sas_state_t st_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CH_W-1:0] cur_reg;
  logic [RES_W-1:0] dac_reg;
  logic [RES_W-1:0] res_reg [NCH];
  logic trig_q_reg;
  logic wr_pend_reg;
  logic rd_wait_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  sas_ctrl_t wd;
  logic ap_take, wr_ctrl, wr_trig, trig_fall, conv_end, is_last;
  logic go_set, go_clr, done_set, done_clr;
  logic [CH_W-1:0] first_ch;
  logic [RES_W-1:0] sar_final;

  // word decode of a register offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : hit

  // one successive approximation decision at bit idx
  function automatic logic [RES_W-1:0] sar_step(
    input logic [RES_W-1:0] d,
    input logic [CNT_W-1:0] idx,
    input logic c
  );
    logic [RES_W-1:0] r;
    r = d;
    if (!c) begin
      r[idx[3:0]] = 1'b0;
    end
    if (idx != '0) begin
      r[idx[3:0] - 4'h1] = 1'b1;
    end
    return r;
  endfunction : sar_step

  // speed dependent reload value of the state counter
  function automatic logic [CNT_W-1:0] ld(
    input logic fast,
    input int s,
    input int f
  );
    return fast ? CNT_W'(cyc(f) - 1) : CNT_W'(cyc(s) - 1);
  endfunction : ld

  // register read multiplexer
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    if (hit(a, CTRL_OFF)) begin
      return {24'h000000, conv_ctrl_status_reg};
    end else if (hit(a, TRIG_OFF)) begin
      return {24'h000000, trigger_ctrl_reg.en, TRIG_ONES,
              trigger_ctrl_reg.rsv0};
    end else if (a[7:5] == RES_SEL) begin
      return {22'h000000, res_reg[a[4:2]]};
    end
    return RD_ZERO;
  endfunction : rd_mux

  ////////////////////////////////////////////////////////////////////////
  // bus slave
  // address phase taken only on an active transfer with hready high
  assign ap_take = hsel & hready & htrans[1];
  assign wr_ctrl = wr_pend_reg & hit(addr_reg, CTRL_OFF);
  assign wr_trig = wr_pend_reg & hit(addr_reg, TRIG_OFF);
  assign wd = sas_ctrl_t'(hwdata[7:0]);
  assign hreadyout = ~rd_wait_reg; // reads take one wait state
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // pipeline of address to data phase; reads sample after any write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= RD_ZERO;
    end else if (ce) begin
      wr_pend_reg <= ap_take & hwrite & (hsize == HSIZE_WORD);
      rd_wait_reg <= ap_take & ~hwrite;
      if (ap_take) begin
        addr_reg <= haddr[7:0];
      end
      if (rd_wait_reg) begin
        hrdata_reg <= rd_mux(addr_reg);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control bits
  // trigger pin edge detector, idles high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_q_reg <= 1'b1;
    end else if (ce) begin
      trig_q_reg <= ext_trigger_pin_n;
    end
  end
  assign trig_fall = trigger_ctrl_reg.en & trig_q_reg
                     & ~ext_trigger_pin_n;

  // a conversion only ends while go stands, so a stop never stores
  assign conv_end = (st_reg == ST_CONV) && (cnt_reg == '0)
                    && conv_ctrl_status_reg.go;
  assign is_last = ~conv_ctrl_status_reg.scan
                   | (cur_reg == conv_ctrl_status_reg.ch);
  assign first_ch = {conv_ctrl_status_reg.ch[2], 2'b00};
  assign sar_final = sar_step(dac_reg, cnt_reg, cmp_hi);

  // go: set by write or trigger, cleared by write, standby, single end
  assign go_set = (wr_ctrl & hwdata[GO_BIT]) | trig_fall;
  assign go_clr = (wr_ctrl & ~hwdata[GO_BIT]) | standby
                  | (conv_end & ~conv_ctrl_status_reg.scan);
  assign done_set = conv_end & is_last;
  assign done_clr = wr_ctrl & ~hwdata[DONE_BIT];

  // control and status register; hardware set beats clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_ctrl_status_reg <= sas_ctrl_t'(CTRL_RST);
    end else if (ce) begin
      if (wr_ctrl) begin
        conv_ctrl_status_reg.irq_en <= wd.irq_en;
        conv_ctrl_status_reg.scan <= wd.scan;
        conv_ctrl_status_reg.speed <= wd.speed;
        conv_ctrl_status_reg.ch <= wd.ch;
      end
      conv_ctrl_status_reg.go <= go_set
        | (conv_ctrl_status_reg.go & ~go_clr);
      conv_ctrl_status_reg.done <= done_set
        | (conv_ctrl_status_reg.done & ~done_clr);
    end
  end

  // trigger control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trigger_ctrl_reg <= '0;
    end else if (ce && wr_trig) begin
      trigger_ctrl_reg.en <= hwdata[DONE_BIT];
      trigger_ctrl_reg.rsv0 <= hwdata[0];
    end
  end

  // interrupt level follows flag and enable
  assign conv_done_irq = conv_ctrl_status_reg.done
                         & conv_ctrl_status_reg.irq_en;

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= ST_IDLE;
      cnt_reg <= '0;
      cur_reg <= '0;
    end else if (ce) begin
      if (!conv_ctrl_status_reg.go) begin
        st_reg <= ST_IDLE;
      end else begin
        unique case (st_reg)
          ST_IDLE: begin
            st_reg <= ST_DELAY;
            cnt_reg <= ld(conv_ctrl_status_reg.speed, TD_SLOW,
                          TD_FAST);
            cur_reg <= conv_ctrl_status_reg.scan ? first_ch
                       : conv_ctrl_status_reg.ch;
          end
          ST_DELAY, ST_GAP: begin
            if (cnt_reg == '0) begin
              st_reg <= ST_SAMP;
              cnt_reg <= ld(conv_ctrl_status_reg.speed, SPL_SLOW,
                            SPL_FAST);
            end else begin
              cnt_reg <= cnt_reg - CNT_W'(1);
            end
          end
          ST_SAMP: begin
            if (cnt_reg == '0) begin
              st_reg <= ST_CONV;
              cnt_reg <= ld(conv_ctrl_status_reg.speed, CNV_SLOW,
                            CNV_FAST);
            end else begin
              cnt_reg <= cnt_reg - CNT_W'(1);
            end
          end
          ST_CONV: begin
            if (cnt_reg != '0) begin
              cnt_reg <= cnt_reg - CNT_W'(1);
            end else if (!conv_ctrl_status_reg.scan) begin
              st_reg <= ST_IDLE;
            end else begin
              st_reg <= ST_GAP;
              cnt_reg <= ld(conv_ctrl_status_reg.speed, GAP_SLOW,
                            GAP_FAST);
              cur_reg <= is_last ? first_ch
                         : cur_reg + CH_W'(1);
            end
          end
          default: begin
            st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // successive approximation register over the last ten convert states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dac_reg <= RES_RST;
    end else if (ce && st_reg == ST_CONV) begin
      if (cnt_reg == CNT_W'(RES_W)) begin
        dac_reg <= SAR_TOP;
      end else if (cnt_reg < CNT_W'(RES_W)) begin
        dac_reg <= sar_final;
      end
    end
  end

  assign an_sel = cur_reg;
  assign sample_en = (st_reg == ST_SAMP);
  assign dac_code = dac_reg;

  // per channel result registers
  for (genvar g = 0; g < NCH; g++) begin : g_res
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        res_reg[g] <= RES_RST;
      end else if (ce && conv_end && cur_reg == CH_W'(g)) begin
        res_reg[g] <= sar_final;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [7:0] meas_reg;
  logic first_reg;
  // cycles since start or since the previous conversion end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meas_reg <= 8'h00;
      first_reg <= 1'b0;
    end else if (ce) begin
      if (st_reg == ST_IDLE || conv_end) begin
        meas_reg <= 8'h00;
      end else begin
        meas_reg <= meas_reg + 8'h01;
      end
      if (st_reg == ST_IDLE) begin
        first_reg <= 1'b1;
      end else if (conv_end) begin
        first_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !ce);

  sequence s_start_slow;
    st_reg == ST_IDLE && conv_ctrl_status_reg.go
      && !conv_ctrl_status_reg.speed ##1 st_reg == ST_DELAY;
  endsequence
  sequence s_start_fast;
    st_reg == ST_IDLE && conv_ctrl_status_reg.go
      && conv_ctrl_status_reg.speed ##1 st_reg == ST_DELAY;
  endsequence

  a_delay_slow: assert property (
    s_start_slow |-> (st_reg == ST_DELAY)[*6] ##1 st_reg == ST_SAMP
  ) else $error("slow start delay not six states");
  a_delay_fast: assert property (
    s_start_fast |-> (st_reg == ST_DELAY)[*4] ##1 st_reg == ST_SAMP
  ) else $error("fast start delay not four states");
  a_first_len: assert property (
    conv_end && first_reg |-> meas_reg == (conv_ctrl_status_reg.speed
      ? 8'(TOT_FAST - 1) : 8'(TOT_SLOW - 1))
  ) else $error("first conversion length wrong");
  a_scan_len: assert property (
    conv_end && !first_reg |-> meas_reg == (conv_ctrl_status_reg.speed
      ? 8'(REP_FAST - 1) : 8'(REP_SLOW - 1))
  ) else $error("repeat conversion length wrong");
  a_single_go_clr: assert property (
    conv_end && !conv_ctrl_status_reg.scan && !trig_fall && !go_set
      |=> !conv_ctrl_status_reg.go && st_reg == ST_IDLE
  ) else $error("single go did not self clear");
  a_scan_go_keep: assert property (
    conv_end && conv_ctrl_status_reg.scan && !go_clr
      |=> conv_ctrl_status_reg.go && st_reg == ST_GAP
  ) else $error("scan go lost at conversion end");
  a_done_set: assert property (
    conv_end && is_last |=> conv_ctrl_status_reg.done
  ) else $error("done flag not set at end");
  a_scan_wrap: assert property (
    conv_end && is_last && conv_ctrl_status_reg.scan && !go_clr
      |=> cur_reg == {$past(conv_ctrl_status_reg.ch[2]), 2'b00}
  ) else $error("scan did not restart at group start");
  a_result_store: assert property (
    conv_end |=> res_reg[$past(cur_reg)] == $past(sar_final)
  ) else $error("result not stored for channel");
  a_trig_start: assert property (
    trig_fall |=> conv_ctrl_status_reg.go
  ) else $error("trigger edge did not set go");
  a_stop_idle: assert property (
    standby && !go_set |=> !conv_ctrl_status_reg.go ##1
      st_reg == ST_IDLE
  ) else $error("standby did not stop conversion");
  a_irq_flag: assert property (
    $fell(conv_ctrl_status_reg.done) |-> $past(done_clr) && !conv_done_irq
  ) else $error("done flag or irq dropped without clear");

endmodule : sas_sar_adc_seq
`default_nettype wire

//--- tb/sas_afe_model.sv
// analog multiplexer and comparator on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_afe_model
  import sas_pkg::*;
(
  input wire logic [CH_W-1:0] an_sel,
  input wire logic [RES_W-1:0] dac_code,
  input wire logic [NCH-1:0][RES_W-1:0] level,
  output logic cmp_hi
);
  // ideal comparator on the selected input, so a search lands on the level
  assign cmp_hi = (level[an_sel] >= dac_code);
endmodule : sas_afe_model
`default_nettype wire

//--- tb/sas_sar_adc_seq_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_sar_adc_seq_tb;
  import sas_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hresp, sample_en;
  logic ext_trigger_pin_n, standby, cmp_hi, conv_done_irq, ce;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [CH_W-1:0] an_sel;
  logic [RES_W-1:0] dac_code, old;
  logic [NCH-1:0][RES_W-1:0] lv;
  int miscompares, n_compared, cyc_n, t0, t1;
  //////////////////////////////////////////////////////////////////////////
  // design, analog partner, clock and cycle count
  sas_sar_adc_seq DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .ext_trigger_pin_n(ext_trigger_pin_n),
    .standby(standby), .cmp_hi(cmp_hi), .an_sel(an_sel),
    .sample_en(sample_en), .dac_code(dac_code),
    .conv_done_irq(conv_done_irq));
  sas_afe_model afe (.an_sel(an_sel), .dac_code(dac_code), .level(lv),
    .cmp_hi(cmp_hi));
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  always @(posedge hclk) cyc_n <= cyc_n + 1;
  //////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bus tasks
  task automatic close_out();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic ran_out();
    miscompares++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    close_out();
  endtask : ran_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // hold the phase until hready is seen high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 64) ran_out();
      @(posedge hclk);
    end
  endtask : wait_rdy
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    hsize <= HSIZE_WORD;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
    input string m);
    bus(a, 1'b0, 32'h0000_0000);
    chk(q, exp, m);
  endtask : rd
  // cycle stamp when sampling (s=1) or the done request (s=0) is seen
  task automatic wait_hi(input bit s, output int t);
    int n;
    n = 0;
    while ((s ? sample_en : conv_done_irq) !== 1'b1) begin
      n++;
      if (n > 3000) ran_out();
      @(posedge hclk);
    end
    t = cyc_n;
  endtask : wait_hi
  function automatic logic [31:0] win(input int d, input int lo, input int hi);
    return {31'h0, (d >= lo && d <= hi)};
  endfunction : win
  function automatic logic [7:0] res(input int n);
    return 8'(32 + 4 * n);
  endfunction : res
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0000_0000;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    ext_trigger_pin_n = 1'b1;
    standby = 1'b0;
    ce = 1'b1;
    cyc_n = 0;
    miscompares = 0;
    n_compared = 0;
    for (int i = 0; i < NCH; i++) begin
      lv[i] = 10'(32'h0a3 + i * 32'h07b);
    end
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // reset values, reserved ones, unmapped place
    rd(CTRL_OFF, 32'h0000_0000, "ctrl reset");
    rd(TRIG_OFF, 32'h0000_007e, "trig reset");
    rd(8'h10, 32'h0000_0000, "unmapped");
    // single, slow, channel 5, request enabled, go set in one write
    bus(CTRL_OFF, 1'b1, 32'h0000_0065);
    t0 = cyc_n;
    wait_hi(1'b1, t1);
    chk(win(t1 - t0, 6, 10), 32'h1, "start delay slow");
    rd(CTRL_OFF, 32'h0000_0065, "go during run");
    wait_hi(1'b0, t1);
    chk(win(t1 - t0, 131, 136), 32'h1, "first conv slow");
    rd(CTRL_OFF, 32'h0000_00c5, "done set go clear");
    rd(res(5), {22'h0, lv[5]}, "single result");
    rd(res(4), 32'h0000_0000, "other channel");
    bus(CTRL_OFF, 1'b1, 32'h0000_0045);
    @(posedge hclk);
    chk({31'h0, conv_done_irq}, 32'h0, "request cleared");
    // scan, fast, inputs 4 to 6
    bus(CTRL_OFF, 1'b1, 32'h0000_007e);
    t0 = cyc_n;
    wait_hi(1'b0, t1);
    chk(win(t1 - t0, 201, 206), 32'h1, "first scan pass");
    for (int i = 4; i < 7; i++) begin
      rd(res(i), {22'h0, lv[i]}, "scan result");
    end
    rd(res(7), 32'h0000_0000, "outside span");
    bus(CTRL_OFF, 1'b1, 32'h0000_007e);
    rd(CTRL_OFF, 32'h0000_007e, "scan go stays");
    wait_hi(1'b0, t0);
    chk(t0 - t1, 32'd198, "repeat pass fast");
    bus(CTRL_OFF, 1'b1, 32'h0000_005e);
    old = lv[4];
    lv[4] = ~old;
    repeat (300) @(posedge hclk);
    rd(res(4), {22'h0, old}, "held when stopped");
    // single, fast, channel 2, started by the trigger pin
    bus(CTRL_OFF, 1'b1, 32'h0000_004a);
    bus(TRIG_OFF, 1'b1, 32'h0000_0080);
    rd(TRIG_OFF, 32'h0000_00fe, "trig enable");
    ext_trigger_pin_n <= 1'b0;
    t0 = cyc_n;
    wait_hi(1'b0, t1);
    ext_trigger_pin_n <= 1'b1;
    chk(win(t1 - t0, 70, 74), 32'h1, "triggered conv");
    rd(CTRL_OFF, 32'h0000_00ca, "triggered single end");
    rd(res(2), {22'h0, lv[2]}, "triggered result");
    // scan, slow, inputs 0 to 1: first pass and result
    bus(CTRL_OFF, 1'b1, 32'h0000_0071);
    t0 = cyc_n;
    @(posedge hclk);
    wait_hi(1'b0, t1);
    chk(win(t1 - t0, 259, 264), 32'h1, "scan pass slow");
    rd(res(1), {22'h0, lv[1]}, "slow scan result");
    bus(CTRL_OFF, 1'b1, 32'h0000_0051);
    old = lv[0];
    lv[0] = ~old;
    // scan, slow, input 0, frozen by ce, then stopped by standby
    bus(CTRL_OFF, 1'b1, 32'h0000_0030);
    repeat (20) @(posedge hclk);
    ce <= 1'b0;
    repeat (200) @(posedge hclk);
    ce <= 1'b1;
    standby <= 1'b1;
    @(posedge hclk);
    standby <= 1'b0;
    rd(CTRL_OFF, 32'h0000_0010, "standby stops");
    repeat (200) @(posedge hclk);
    rd(res(0), {22'h0, old}, "no result after stop");
    chk({31'h0, hresp}, 32'h0, "okay response");
    close_out();
  end
endmodule : sas_sar_adc_seq_tb
`default_nettype wire
